// file: hw/acc_alu_pkg.sv
// Shared constants, types and helpers of the accumulator datapath slice
package acc_alu_pkg;
	// Register bus geometry
	localparam int ADDR_W = 12;
	localparam logic [11:0] REG_INSTR = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_FLAGS = 12'h008;
	localparam logic [11:0] REG_ACC = 12'h00C;
	localparam logic [1:0] MEM_WINDOW = 2'h1;
	localparam int MEM_DEPTH = 256;
	// Status register fields
	localparam int ST_BUSY = 0;
	localparam int ST_UNKNOWN = 1;
	// Flag register fields
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_NIBBLE = 1;
	localparam int FLAG_ZERO = 2;
	localparam int FLAG_SIGNED = 3;
	// Instruction word fields and encodings
	localparam int DEST_BIT = 8;
	localparam logic [6:0] ENC_ADD = 7'h07;
	localparam logic [6:0] ENC_ADDC = 7'h08;
	localparam logic [7:0] ENC_AND = 8'hB5;
	// Reset values
	localparam logic [15:0] INSTR_RESET = 16'h0000;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] MEM_RESET = 8'h00;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_ADD = 2'b01,
		OP_ADDC = 2'b10,
		OP_AND = 2'b11
	} op_t;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_DECODE = 3'b001,
		PH_READ = 3'b010,
		PH_PROCESS = 3'b011,
		PH_WRITE = 3'b100
	} phase_t;

	// Byte-lane merge of a write under its strobes
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Word address legality check
	function automatic logic addr_mapped(input logic [11:0] a);
		return (a[1:0] == 2'h0) && ((a == REG_INSTR) || (a == REG_STATUS) ||
			(a == REG_FLAGS) || (a == REG_ACC) || (a[11:10] == MEM_WINDOW));
	endfunction
endpackage

// file: hw/op_decoder.sv
// Instruction word decoder for the three datapath operations
`timescale 1ns/1ps
module op_decoder
	import acc_alu_pkg::*;
(
	input wire logic [15:0] word_in,
	output op_t op_out,
	output logic dest_out,
	output logic [7:0] field_out
);
	// Upper bits pick the operation, low byte is index or immediate
	always_comb begin
		op_out = OP_NONE;
		if (word_in[15:9] == ENC_ADD) begin
			op_out = OP_ADD;
		end else if (word_in[15:9] == ENC_ADDC) begin
			op_out = OP_ADDC;
		end else if (word_in[15:8] == ENC_AND) begin
			op_out = OP_AND;
		end
		dest_out = word_in[DEST_BIT];
		field_out = word_in[7:0];
	end
endmodule

// file: hw/alu_slice.sv
// Adder and AND unit with status flag computation
`timescale 1ns/1ps
module alu_slice
	import acc_alu_pkg::*;
(
	input op_t op_in,
	input wire logic [7:0] acc_in,
	input wire logic [7:0] opnd_in,
	input wire logic [3:0] flags_in,
	output logic [7:0] result_out,
	output logic [3:0] flags_out
);
	logic cin;
	logic [8:0] sum;
	logic [4:0] low;

	// Carry enters only for the add-with-spill operation
	assign cin = (op_in == OP_ADDC) ? flags_in[FLAG_CARRY] : 1'b0;
	assign sum = {1'b0, acc_in} + {1'b0, opnd_in} + {8'h00, cin};
	assign low = {1'b0, acc_in[3:0]} + {1'b0, opnd_in[3:0]} + {4'h0, cin};

	// Result and flag selection per operation
	always_comb begin
		result_out = sum[7:0];
		flags_out = flags_in;
		unique case (op_in)
			OP_NONE: begin
				result_out = acc_in;
			end
			OP_ADD, OP_ADDC: begin
				flags_out[FLAG_CARRY] = sum[8];
				flags_out[FLAG_NIBBLE] = low[4];
				flags_out[FLAG_ZERO] = (sum[7:0] == 8'h00);
				flags_out[FLAG_SIGNED] = (acc_in[7] == opnd_in[7]) &&
					(sum[7] != acc_in[7]);
			end
			OP_AND: begin
				result_out = acc_in & opnd_in;
				flags_out[FLAG_ZERO] = ((acc_in & opnd_in) == 8'h00);
			end
		endcase
	end
endmodule

// file: hw/accumulator_add_and_logic_ops.sv
// Accumulator datapath slice with AXI4-Lite register access
//
// Overview of operation
// - Add accumulator to one of 256 registers
// - Target bit picks accumulator or register
// - Add opcode is upper bits 0000 111d
// - Both adds update all four flags
// - Add-with-spill opcode is 0001 000d
// - AND immediate opcode is 1011 0101
// - AND immediate changes only zero flag
// - One cycle of four phases
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module accumulator_add_and_logic_ops
	import acc_alu_pkg::*;
(
	input wire logic MCLK_IN,
	input wire logic RST_N_IN,
	input wire logic [11:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	output logic [1:0] S_AXI_BRESP_OUT,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic [11:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN
);
	logic aw_held;
	logic w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic busy;
	logic start;
	logic sw_idle_wr;
	logic [31:0] rd_word;
	logic [15:0] instr_word;
	logic [7:0] working_accumulator;
	logic [7:0] mem [MEM_DEPTH];
	logic [3:0] flags;
	logic unknown_op;
	phase_t phase;
	op_t dec_op;
	logic dec_dest;
	logic [7:0] dec_field;
	op_t op_q;
	logic dest_q;
	logic [7:0] field_q;
	logic [7:0] operand;
	logic [7:0] alu_result;
	logic [3:0] alu_flags;
	logic [7:0] result;
	logic [3:0] flags_calc;
	logic [31:0] merged;

	// Write takes effect once address and data are both held
	assign do_write = aw_held && w_held && !S_AXI_BVALID_OUT;
	assign busy = (phase != PH_IDLE);
	assign start = do_write && (aw_addr == REG_INSTR) && !busy;
	assign sw_idle_wr = do_write && !busy;

	// Current word at a register address, for reads and lane merges
	function automatic logic [31:0] rd_word_of(input logic [11:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (a == REG_INSTR) begin
			r = {16'h0000, instr_word};
		end else if (a == REG_STATUS) begin
			r = {30'h0000_0000, unknown_op, busy};
		end else if (a == REG_FLAGS) begin
			r = {28'h000_0000, flags};
		end else if (a == REG_ACC) begin
			r = {24'h00_0000, working_accumulator};
		end else if (a[11:10] == MEM_WINDOW) begin
			r = {24'h00_0000, mem[a[9:2]]};
		end
		return r;
	endfunction

	// Read word and merged write word follow register contents, not only the addresses
	always_comb begin
		rd_word = rd_word_of(S_AXI_ARADDR_IN);
		merged = lane_merge(rd_word_of(aw_addr), w_data, w_strb);
	end

	// Write address channel
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			S_AXI_AWREADY_OUT <= 1'b0;
			aw_held <= 1'b0;
			aw_addr <= 12'h000;
		end else if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
			S_AXI_AWREADY_OUT <= 1'b0;
			aw_held <= 1'b1;
			aw_addr <= S_AXI_AWADDR_IN;
		end else begin
			if (do_write) begin
				aw_held <= 1'b0;
			end
			if (!aw_held && !S_AXI_BVALID_OUT) begin
				S_AXI_AWREADY_OUT <= 1'b1;
			end
		end
	end

	// Write data channel
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			S_AXI_WREADY_OUT <= 1'b0;
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
			S_AXI_WREADY_OUT <= 1'b0;
			w_held <= 1'b1;
			w_data <= S_AXI_WDATA_IN;
			w_strb <= S_AXI_WSTRB_IN;
		end else begin
			if (do_write) begin
				w_held <= 1'b0;
			end
			if (!w_held && !S_AXI_BVALID_OUT) begin
				S_AXI_WREADY_OUT <= 1'b1;
			end
		end
	end

	// Write response channel
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			S_AXI_BVALID_OUT <= 1'b0;
			S_AXI_BRESP_OUT <= RESP_OKAY;
		end else if (do_write) begin
			S_AXI_BVALID_OUT <= 1'b1;
			S_AXI_BRESP_OUT <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY_IN) begin
			S_AXI_BVALID_OUT <= 1'b0;
		end
	end

	// Read channels, data captured at the address handshake
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			S_AXI_ARREADY_OUT <= 1'b0;
			S_AXI_RVALID_OUT <= 1'b0;
			S_AXI_RDATA_OUT <= 32'h0000_0000;
			S_AXI_RRESP_OUT <= RESP_OKAY;
		end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
			S_AXI_ARREADY_OUT <= 1'b0;
			S_AXI_RVALID_OUT <= 1'b1;
			S_AXI_RDATA_OUT <= rd_word;
			S_AXI_RRESP_OUT <= addr_mapped(S_AXI_ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RVALID_OUT) begin
			if (S_AXI_RREADY_IN) begin
				S_AXI_RVALID_OUT <= 1'b0;
			end
		end else begin
			S_AXI_ARREADY_OUT <= 1'b1;
		end
	end

	// Instruction register, loaded only while idle
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			instr_word <= INSTR_RESET;
		end else if (start) begin
			instr_word <= merged[15:0];
		end
	end

	// Four-phase sequencer
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			phase <= PH_IDLE;
		end else begin
			unique case (phase)
				PH_IDLE: begin
					if (start) begin
						phase <= PH_DECODE;
					end
				end
				PH_DECODE: begin
					phase <= PH_READ;
				end
				PH_READ: begin
					phase <= PH_PROCESS;
				end
				PH_PROCESS: begin
					phase <= PH_WRITE;
				end
				PH_WRITE: begin
					phase <= PH_IDLE;
				end
				default: begin
					phase <= PH_IDLE;
				end
			endcase
		end
	end

	op_decoder u_decoder (
		.word_in(instr_word),
		.op_out(dec_op),
		.dest_out(dec_dest),
		.field_out(dec_field)
	);

	// Decode latch, operand read and processing stages
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			op_q <= OP_NONE;
			dest_q <= 1'b0;
			field_q <= 8'h00;
			operand <= 8'h00;
			result <= 8'h00;
			flags_calc <= FLAGS_RESET;
		end else begin
			if (phase == PH_DECODE) begin
				op_q <= dec_op;
				dest_q <= dec_dest;
				field_q <= dec_field;
			end
			if (phase == PH_READ) begin
				operand <= (op_q == OP_AND) ? field_q : mem[field_q];
			end
			if (phase == PH_PROCESS) begin
				result <= alu_result;
				flags_calc <= alu_flags;
			end
		end
	end

	alu_slice u_alu (
		.op_in(op_q),
		.acc_in(working_accumulator),
		.opnd_in(operand),
		.flags_in(flags),
		.result_out(alu_result),
		.flags_out(alu_flags)
	);

	// Working accumulator: result write or software write while idle
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			working_accumulator <= ACC_RESET;
		end else if (phase == PH_WRITE && op_q != OP_NONE && (op_q == OP_AND || !dest_q)) begin
			working_accumulator <= result;
		end else if (sw_idle_wr && aw_addr == REG_ACC) begin
			working_accumulator <= merged[7:0];
		end
	end

	// Data register file
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			for (int i = 0; i < MEM_DEPTH; i++) begin
				mem[i] <= MEM_RESET;
			end
		end else if (phase == PH_WRITE && (op_q == OP_ADD || op_q == OP_ADDC) && dest_q) begin
			mem[field_q] <= result;
		end else if (sw_idle_wr && aw_addr[11:10] == MEM_WINDOW && aw_addr[1:0] == 2'h0) begin
			mem[aw_addr[9:2]] <= merged[7:0];
		end
	end

	// Status flags, committed at the write phase
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			flags <= FLAGS_RESET;
		end else if (phase == PH_WRITE && op_q != OP_NONE) begin
			flags <= flags_calc;
		end else if (sw_idle_wr && aw_addr == REG_FLAGS) begin
			flags <= merged[3:0];
		end
	end

	// Sticky unknown-opcode bit, set wins over a write-one clear
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			unknown_op <= 1'b0;
		end else if (phase == PH_DECODE && dec_op == OP_NONE) begin
			unknown_op <= 1'b1;
		end else if (do_write && aw_addr == REG_STATUS && w_strb[0] && w_data[ST_UNKNOWN]) begin
			unknown_op <= 1'b0;
		end
	end

	// Checks on the datapath
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RST_N_IN);

	sequence s_phases;
		phase == PH_DECODE ##1 phase == PH_READ ##1 phase == PH_PROCESS
			##1 phase == PH_WRITE ##1 phase == PH_IDLE;
	endsequence

	property p_phase_walk;
		start |=> s_phases;
	endproperty
	a_phase_walk: assert property (p_phase_walk) else $error("phase walk broken");

	property p_add_sum;
		(phase == PH_PROCESS && op_q == OP_ADD) |=>
			result == 8'($past(working_accumulator) + $past(operand));
	endproperty
	a_add_sum: assert property (p_add_sum) else $error("add result wrong");

	property p_addc_sum;
		(phase == PH_PROCESS && op_q == OP_ADDC) |=> result == 8'($past(working_accumulator)
			+ $past(operand) + {7'h00, $past(flags[FLAG_CARRY])});
	endproperty
	a_addc_sum: assert property (p_addc_sum) else $error("add with carry wrong");

	property p_dest_acc;
		(phase == PH_WRITE && op_q inside {OP_ADD, OP_ADDC} && !dest_q) |=>
			working_accumulator == $past(result);
	endproperty
	a_dest_acc: assert property (p_dest_acc) else $error("accumulator not written");

	property p_dest_mem;
		(phase == PH_WRITE && op_q inside {OP_ADD, OP_ADDC} && dest_q) |=>
			mem[$past(field_q)] == $past(result) && $stable(working_accumulator);
	endproperty
	a_dest_mem: assert property (p_dest_mem) else $error("register not written");

	property p_decode_add;
		(phase == PH_DECODE && instr_word[15:9] == ENC_ADD) |=> op_q == OP_ADD;
	endproperty
	a_decode_add: assert property (p_decode_add) else $error("add not decoded");

	property p_decode_addc;
		(phase == PH_DECODE && instr_word[15:9] == ENC_ADDC) |=> op_q == OP_ADDC;
	endproperty
	a_decode_addc: assert property (p_decode_addc) else $error("addc not decoded");

	property p_decode_and;
		(phase == PH_DECODE && instr_word[15:8] == ENC_AND) |=> op_q == OP_AND;
	endproperty
	a_decode_and: assert property (p_decode_and) else $error("and not decoded");

	property p_and_result;
		(phase == PH_PROCESS && op_q == OP_AND) |=> ##1
			working_accumulator == ($past(working_accumulator, 2) & $past(operand, 2));
	endproperty
	a_and_result: assert property (p_and_result) else $error("and result wrong");

	property p_and_flags;
		(phase == PH_WRITE && op_q == OP_AND) |=> flags[FLAG_CARRY] == $past(flags[FLAG_CARRY])
			&& flags[FLAG_NIBBLE] == $past(flags[FLAG_NIBBLE])
			&& flags[FLAG_SIGNED] == $past(flags[FLAG_SIGNED]);
	endproperty
	a_and_flags: assert property (p_and_flags) else $error("and touched flags");

	property p_add_carry;
		(phase == PH_PROCESS && op_q == OP_ADD) |=> flags_calc[FLAG_CARRY] ==
			(({1'b0, $past(working_accumulator)} + {1'b0, $past(operand)}) > 9'h0FF);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("carry flag wrong");

	property p_add_nibble;
		(phase == PH_PROCESS && op_q == OP_ADD) |=> flags_calc[FLAG_NIBBLE] ==
			(({1'b0, $past(working_accumulator[3:0])} + {1'b0, $past(operand[3:0])}) > 5'h0F);
	endproperty
	a_add_nibble: assert property (p_add_nibble) else $error("nibble flag wrong");

	property p_zero;
		(phase == PH_WRITE && op_q != OP_NONE) |=> flags[FLAG_ZERO] == ($past(result) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule

// file: bench/axi_host.sv
// Register bus host model issuing single AXI4-Lite transfers
`timescale 1ns/1ps
module axi_host (
	input wire logic clk_in,
	input wire logic rst_n_in,
	output logic [11:0] awaddr_out,
	output logic awvalid_out,
	input wire logic awready_in,
	output logic [31:0] wdata_out,
	output logic [3:0] wstrb_out,
	output logic wvalid_out,
	input wire logic wready_in,
	input wire logic [1:0] bresp_in,
	input wire logic bvalid_in,
	output logic bready_out,
	output logic [11:0] araddr_out,
	output logic arvalid_out,
	input wire logic arready_in,
	input wire logic [31:0] rdata_in,
	input wire logic [1:0] rresp_in,
	input wire logic rvalid_in,
	output logic rready_out
);
	// Set when a transfer never got its answer
	logic tmo = 1'b0;
	// Quiet bus at time zero
	initial begin
		awaddr_out = 12'hFFF;
		awvalid_out = 1'b0;
		wdata_out = 32'h0;
		wstrb_out = 4'h0;
		wvalid_out = 1'b0;
		bready_out = 1'b0;
		araddr_out = 12'hFFF;
		arvalid_out = 1'b0;
		rready_out = 1'b0;
	end
	// One write; released payload is inverted so stale values never match
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk_in);
		awaddr_out <= a;
		awvalid_out <= 1'b1;
		wdata_out <= d;
		wstrb_out <= 4'hF;
		wvalid_out <= 1'b1;
		bready_out <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (awvalid_out && awready_in) begin
				awvalid_out <= 1'b0;
				awaddr_out <= ~a;
			end
			if (wvalid_out && wready_in) begin
				wvalid_out <= 1'b0;
				wdata_out <= ~d;
			end
		end while (!bvalid_in && n < 200);
		bready_out <= 1'b0;
		r = bresp_in;
		if (n >= 200) tmo = 1'b1;
	endtask
	// One read; data taken at the edge that sees the answer
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk_in);
		araddr_out <= a;
		arvalid_out <= 1'b1;
		rready_out <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (arvalid_out && arready_in) begin
				arvalid_out <= 1'b0;
				araddr_out <= ~a;
			end
		end while (!rvalid_in && n < 200);
		rready_out <= 1'b0;
		d = rdata_in;
		r = rresp_in;
		if (n >= 200) tmo = 1'b1;
	endtask
endmodule

// file: bench/accumulator_add_and_logic_ops_tb.sv
// Self-checking bench for the accumulator datapath slice
`timescale 1ns/1ps
module accumulator_add_and_logic_ops_tb
	import acc_alu_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, lfsr;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	op_t k;
	int error_cnt = 0;
	int checks = 0;
	// 100 MHz clock
	always #5 clk = ~clk;
	accumulator_add_and_logic_ops dut_u (
		.MCLK_IN(clk),
		.RST_N_IN(rst_n),
		.S_AXI_AWADDR_IN(awaddr),
		.S_AXI_AWVALID_IN(awvalid),
		.S_AXI_AWREADY_OUT(awready),
		.S_AXI_WDATA_IN(wdata),
		.S_AXI_WSTRB_IN(wstrb),
		.S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(wready),
		.S_AXI_BRESP_OUT(bresp),
		.S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready),
		.S_AXI_ARADDR_IN(araddr),
		.S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(arready),
		.S_AXI_RDATA_OUT(rdata),
		.S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid),
		.S_AXI_RREADY_IN(rready)
	);
	axi_host host_u (
		.clk_in(clk),
		.rst_n_in(rst_n),
		.awaddr_out(awaddr),
		.awvalid_out(awvalid),
		.awready_in(awready),
		.wdata_out(wdata),
		.wstrb_out(wstrb),
		.wvalid_out(wvalid),
		.wready_in(wready),
		.bresp_in(bresp),
		.bvalid_in(bvalid),
		.bready_out(bready),
		.araddr_out(araddr),
		.arvalid_out(arvalid),
		.arready_in(arready),
		.rdata_in(rdata),
		.rresp_in(rresp),
		.rvalid_in(rvalid),
		.rready_out(rready)
	);
	// Next pseudo-random word
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected {signed, zero, nibble, carry, result} of one operation
	function automatic logic [11:0] model(input op_t o, input logic [7:0] a, input logic [7:0] b,
		input logic [3:0] f);
		logic [8:0] s;
		logic [4:0] h;
		logic ci;
		ci = (o == OP_ADDC) ? f[0] : 1'b0;
		s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		if (o == OP_AND) begin
			s[7:0] = a & b;
			return {f[3], s[7:0] == 8'h00, f[1:0], s[7:0]};
		end
		return {(a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
	endfunction
	// Verdict and end of run
	task automatic stop_test();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Compare one value
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// Bus write with expected response
	task automatic wv(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		logic [1:0] r;
		host_u.wr(a, d, r);
		chk("bresp", {30'h0, er}, {30'h0, r});
		if (host_u.tmo) begin
			chk("bus timeout", 32'h0, 32'h1);
			stop_test();
		end
	endtask
	// Bus read with expected data and response
	task automatic rv(input logic [11:0] a, input logic [31:0] e, input string n,
		input logic [1:0] er = RESP_OKAY);
		logic [31:0] v;
		logic [1:0] r;
		host_u.rd(a, v, r);
		chk("rresp", {30'h0, er}, {30'h0, r});
		chk(n, e, v);
		if (host_u.tmo) begin
			chk("bus timeout", 32'h0, 32'h1);
			stop_test();
		end
	endtask
	// Wait until the busy bit drops, bounded
	task automatic idle();
		logic [31:0] v;
		logic [1:0] r;
		int n;
		n = 0;
		do begin
			host_u.rd(REG_STATUS, v, r);
			n++;
		end while (v[0] !== 1'b0 && n < 20);
		if (v[0] !== 1'b0) begin
			chk("busy timeout", 32'h0, {31'h0, v[0]});
			stop_test();
		end
	endtask
	// Load operands, issue one instruction, check every destination
	task automatic run(input op_t o, input logic d, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] i, input logic [3:0] f);
		logic [11:0] e;
		logic [11:0] m;
		logic w;
		e = model(o, a, b, f);
		m = {2'b01, i, 2'b00};
		w = d && (o != OP_AND);
		wv(REG_ACC, {24'h0, a});
		wv(REG_FLAGS, {28'h0, f});
		wv(m, {24'h0, b});
		if (o == OP_AND) wv(REG_INSTR, {16'h0, 8'hB5, b});
		else wv(REG_INSTR, {16'h0, (o == OP_ADD) ? 7'h07 : 7'h08, d, i});
		idle();
		rv(REG_ACC, {24'h0, w ? a : e[7:0]}, "acc");
		rv(REG_FLAGS, {28'h0, e[11:8]}, "flags");
		rv(m, {24'h0, w ? e[7:0] : b}, "reg");
	endtask
	// Main sequence
	initial begin
		lfsr = 32'h7F87;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rv(REG_ACC, 32'h0, "acc reset");
		rv(REG_FLAGS, 32'h0, "flags reset");
		rv(REG_STATUS, 32'h0, "status reset");
		rv(12'h7FC, 32'h0, "reg reset");
		rv(12'h010, 32'h0, "unmapped", RESP_SLVERR);
		wv(12'h002, 32'h5A, RESP_SLVERR);
		run(OP_ADD, 1'b0, 8'h17, 8'hC2, 8'h00, 4'h0);
		run(OP_ADDC, 1'b0, 8'h4D, 8'h02, 8'hFF, 4'h1);
		run(OP_ADDC, 1'b1, 8'h80, 8'h80, 8'h3C, 4'h1);
		run(OP_ADD, 1'b1, 8'h08, 8'h08, 8'hFF, 4'h0);
		run(OP_AND, 1'b0, 8'hA3, 8'h5F, 8'h10, 4'h0);
		run(OP_AND, 1'b1, 8'hA3, 8'h5C, 8'h10, 4'hB);
		// Unknown code: sticky bit set, accumulator kept, write during busy ignored
		wv(REG_ACC, 32'h3C);
		wv(REG_INSTR, 32'hFF00);
		wv(REG_ACC, 32'hC3);
		idle();
		rv(REG_STATUS, 32'h2, "unknown op");
		rv(REG_ACC, 32'h3C, "acc busy write");
		wv(REG_STATUS, 32'h2);
		rv(REG_STATUS, 32'h0, "unknown clear");
		repeat (40) begin
			lfsr = step(lfsr);
			k = (lfsr[1:0] == 2'h1) ? OP_ADD : (lfsr[1:0] == 2'h2) ? OP_ADDC : OP_AND;
			run(k, lfsr[2], lfsr[15:8], lfsr[23:16], lfsr[31:24], lfsr[7:4]);
		end
		stop_test();
	end
endmodule
